/* File: shared/field_pwm_regs.svh */
// offsets, field positions, reset values and timing counts of the field pwm
`ifndef FIELD_PWM_REGS_SVH
`define FIELD_PWM_REGS_SVH

`define CLK_HZ 125000000
`define PWM_STEPS 256
`define PWM_NORM_HZ 220
`define PWM_PRE_HZ 27
`define STEP_DIV_NORM (`CLK_HZ / (`PWM_NORM_HZ * `PWM_STEPS))
`define STEP_DIV_PRE (`CLK_HZ / (`PWM_PRE_HZ * `PWM_STEPS))
`define MS_DIV (`CLK_HZ / 1000)

`define FORCE_ON_DELAY_MS 400
`define BOOST_OFF_MS 282
`define BOOST_ON_MS0 27
`define BOOST_ON_MS1 70
`define BOOST_ON_MS2 112
`define BOOST_ON_MS3 155

`define DUTY_FULL 9'h100
`define DUTY_MAX_LIMITED 9'h0F5
`define RISE_BLIND 9'h004
`define UPD_MAX 6'h20
`define TEMP_STEP_PERIODS 5'h1F
`define TEMP_THR_BASE 8'hAF
`define TEMP_THR_STEP 8'h05

`define ADDR_CTRL 4'h0
`define ADDR_LIMIT 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_TEMP 4'hC
`define CTRL_LIMIT_EN 0
`define CTRL_RISE_EN 1
`define CTRL_STEP_LSB 4
`define CTRL_RESET 32'h0000_0010
`define LIMIT_RESET 8'hFF

`endif

/* File: shared/field_pwm_pkg.sv */
// types shared by the field excitation pwm block
`default_nettype none
package field_pwm_pkg;
	typedef enum logic [3:0] {
		OP_COMACT = 4'b0001,
		OP_PRE = 4'b0010,
		OP_NORMAL = 4'b0100,
		OP_DEFAULT = 4'b1000
	} op_state_e;
	typedef enum logic [2:0] {
		B_IDLE = 3'b001,
		B_ON = 3'b010,
		B_OFF = 3'b100
	} boost_e;
	typedef logic [8:0] duty_t;
	typedef struct packed {
		logic [2:0] preexc_duty_field;
		logic [2:0] boost_on_time_field;
		logic [2:0] high_temp_threshold;
		logic [2:0] high_temp_slope;
	} nvm_cfg_s;
endpackage
`default_nettype wire

/* File: rtl/field_excitation_pwm_regulation.sv */
// field excitation pwm generation and regulation logic
`include "field_pwm_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module field_excitation_pwm_regulation #(
	parameter int STEP_DIV_NORM = `STEP_DIV_NORM,
	parameter int STEP_DIV_PRE = `STEP_DIV_PRE,
	parameter int MS_DIV = `MS_DIV
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [3:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire field_pwm_pkg::op_state_e OP_STATE,
	input wire field_pwm_pkg::nvm_cfg_s NVM_CFG,
	input wire field_pwm_pkg::duty_t REG_DUTY,
	input wire logic [7:0] VOLTAGE_SETPOINT,
	input wire logic [7:0] FIELD_CURRENT_SAMPLE,
	input wire logic [7:0] TEMP_SAMPLE,
	input wire logic OVER_CURRENT,
	input wire logic VBA_BELOW_MIN,
	input wire logic VBA_ABOVE_MAX,
	input wire logic FORCE_ON_ENABLE,
	input wire logic PHASE_PRESENT,
	output logic FIELD_SWITCH,
	output logic HIGH_TEMP_FLAG,
	output logic [7:0] SETPOINT_OUT
);
	import field_pwm_pkg::*;

	logic [31:0] ctrl_reg;
	logic [7:0] current_limit_reg;
	logic [14:0] div_reg;
	logic [7:0] pos_reg;
	logic [16:0] ms_div_reg;
	duty_t duty_reg;
	logic oc_reg;
	logic off_seen_reg;
	logic [7:0] avg_reg;
	logic [7:0] measured_field_current;
	logic [5:0] upd_reg;
	duty_t lim_duty_reg;
	duty_t lrc_reg;
	logic lrc_active_reg;
	logic [7:0] temp_filt_reg;
	logic [4:0] temp_cnt_reg;
	logic [8:0] fo_cnt_reg;
	logic fo_armed_reg;
	logic fo_active_reg;
	boost_e boost_reg;
	logic [8:0] boost_cnt_reg;

	logic limit_en;
	logic rise_en;
	logic [3:0] rise_step;
	logic pre_mode;
	logic run_mode;
	logic step_en;
	logic period_start;
	logic ms_tick;
	logic meas_due;
	logic force_gap;
	logic on_now;
	logic low_voltage_force_on;
	logic high_voltage_force_off;
	logic phase_signal_boost;
	logic [14:0] div_max;
	logic [8:0] limit_gap;
	logic [5:0] upd_next;
	duty_t capped;
	duty_t rise_limiter;
	duty_t duty_next;
	logic [8:0] boost_on_ms;
	logic [7:0] high_temp_threshold;
	logic [11:0] setpoint_drop;

	assign limit_en = ctrl_reg[`CTRL_LIMIT_EN];
	assign rise_en = ctrl_reg[`CTRL_RISE_EN];
	assign rise_step = ctrl_reg[`CTRL_STEP_LSB +: 4];
	assign pre_mode = (OP_STATE == OP_PRE);
	assign run_mode = (OP_STATE == OP_NORMAL) || (OP_STATE == OP_DEFAULT);
	assign high_voltage_force_off = VBA_ABOVE_MAX;
	assign low_voltage_force_on = fo_active_reg;
	assign phase_signal_boost = (boost_reg != B_IDLE);

	// slower period in pre-excitation
	assign div_max = pre_mode ? 15'(STEP_DIV_PRE - 1) : 15'(STEP_DIV_NORM - 1);
	assign step_en = (div_reg >= div_max);
	assign period_start = step_en && (pos_reg == 8'hFF);
	assign ms_tick = (ms_div_reg == 17'(MS_DIV - 1));

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			div_reg <= 15'h0000;
			pos_reg <= 8'h00;
		end else if (step_en) begin
			div_reg <= 15'h0000;
			pos_reg <= pos_reg + 8'h01;
		end else begin
			div_reg <= div_reg + 15'h0001;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			ms_div_reg <= 17'h00000;
		else if (ms_tick)
			ms_div_reg <= 17'h00000;
		else
			ms_div_reg <= ms_div_reg + 17'h00001;
	end

	// software registers
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl_reg <= `CTRL_RESET;
			current_limit_reg <= `LIMIT_RESET;
		end else if (WR) begin
			unique case (ADDR)
				`ADDR_CTRL: ctrl_reg <= {24'h000000, WDATA[7:4], 2'h0,
					WDATA[1:0]};
				`ADDR_LIMIT: current_limit_reg <= WDATA[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			RDATA <= 32'h0000_0000;
		else if (RD) begin
			unique case (ADDR)
				`ADDR_CTRL: RDATA <= ctrl_reg;
				`ADDR_LIMIT: RDATA <= {24'h000000, current_limit_reg};
				`ADDR_STATUS: RDATA <= {10'h000, phase_signal_boost,
					fo_armed_reg, HIGH_TEMP_FLAG, lrc_active_reg, 1'b0,
					duty_reg, measured_field_current};
				`ADDR_TEMP: RDATA <= {16'h0000, SETPOINT_OUT,
					temp_filt_reg};
				default: RDATA <= 32'h0000_0000;
			endcase
		end
	end

	// over-current latch; a hit at the boundary still wins
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			oc_reg <= 1'b0;
		else if (OVER_CURRENT)
			oc_reg <= 1'b1;
		else if (period_start)
			oc_reg <= 1'b0;
	end

	// a full-on period leaves no off step: steal the last one
	assign meas_due = (upd_reg == 6'h00);
	assign force_gap = meas_due && !off_seen_reg && (pos_reg == 8'hFF);
	assign on_now = ({1'b0, pos_reg} < duty_reg);

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			FIELD_SWITCH <= 1'b0;
		else
			FIELD_SWITCH <= on_now && !oc_reg && !OVER_CURRENT &&
				!force_gap && !high_voltage_force_off;
	end

	// off-time sampling and averaging
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			avg_reg <= 8'h00;
			off_seen_reg <= 1'b0;
		end else if (step_en && !FIELD_SWITCH) begin
			avg_reg <= 8'((9'(avg_reg) + 9'(FIELD_CURRENT_SAMPLE)) >> 1);
			off_seen_reg <= !period_start;
		end else if (period_start) begin
			off_seen_reg <= 1'b0;
		end
	end

	// update interval shrinks as the current nears the limit
	assign limit_gap = 9'(current_limit_reg) - 9'(measured_field_current);
	always_comb begin
		if (!limit_en || limit_gap[8] == 1'b0 && limit_gap >= 9'(`UPD_MAX))
			upd_next = `UPD_MAX - 6'h01;
		else if (limit_gap[8] || limit_gap == 9'h000)
			upd_next = 6'h00;
		else
			upd_next = 6'(limit_gap - 9'h001);
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			upd_reg <= 6'h00;
			measured_field_current <= 8'h00;
		end else if (period_start) begin
			if (meas_due) begin
				measured_field_current <= avg_reg;
				upd_reg <= upd_next;
			end else begin
				upd_reg <= upd_reg - 6'h01;
			end
		end
	end

	// current limiting trims a duty ceiling on each fresh value
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			lim_duty_reg <= `DUTY_FULL;
		else if (!limit_en)
			lim_duty_reg <= `DUTY_FULL;
		else if (period_start && meas_due) begin
			if (avg_reg > current_limit_reg && lim_duty_reg != 9'h000)
				lim_duty_reg <= lim_duty_reg - 9'h001;
			else if (avg_reg < current_limit_reg &&
				lim_duty_reg < `DUTY_FULL)
				lim_duty_reg <= lim_duty_reg + 9'h001;
		end
	end

	always_comb begin
		capped = REG_DUTY > `DUTY_FULL ? `DUTY_FULL : REG_DUTY;
		if (capped > lim_duty_reg)
			capped = lim_duty_reg;
		if (limit_en && capped > `DUTY_MAX_LIMITED)
			capped = `DUTY_MAX_LIMITED;
	end

	// rise limiter; boost never touches it
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			lrc_reg <= 9'h000;
			lrc_active_reg <= 1'b0;
		end else if (!rise_en || rise_step == 4'h0) begin
			lrc_reg <= capped;
			lrc_active_reg <= 1'b0;
		end else if (fo_armed_reg && FORCE_ON_ENABLE && VBA_BELOW_MIN &&
			!fo_active_reg) begin
			lrc_reg <= `DUTY_FULL;
		end else if (period_start) begin
			if (capped > lrc_reg + `RISE_BLIND)
				lrc_active_reg <= 1'b1;
			else if (capped <= lrc_reg)
				lrc_active_reg <= 1'b0;
			if (capped > lrc_reg)
				lrc_reg <= (capped - lrc_reg > 9'(rise_step)) ?
					lrc_reg + 9'(rise_step) : capped;
			else if (lrc_reg - capped > 9'(rise_step))
				lrc_reg <= lrc_reg - 9'(rise_step);
			else
				lrc_reg <= capped;
		end
	end

	assign rise_limiter = lrc_active_reg ? lrc_reg : capped;

	// low-voltage force-on arming delay
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			fo_cnt_reg <= 9'h000;
			fo_armed_reg <= 1'b0;
			fo_active_reg <= 1'b0;
		end else if (!FORCE_ON_ENABLE) begin
			fo_cnt_reg <= 9'h000;
			fo_armed_reg <= 1'b0;
			fo_active_reg <= 1'b0;
		end else begin
			if (!fo_armed_reg && VBA_BELOW_MIN)
				fo_cnt_reg <= 9'h000;
			else if (!fo_armed_reg && ms_tick) begin
				if (fo_cnt_reg == 9'(`FORCE_ON_DELAY_MS - 1))
					fo_armed_reg <= 1'b1;
				fo_cnt_reg <= fo_cnt_reg + 9'h001;
			end
			fo_active_reg <= fo_armed_reg && VBA_BELOW_MIN;
		end
	end

	// phase boost sequencer
	always_comb begin
		unique case (NVM_CFG.boost_on_time_field[1:0])
			2'h0: boost_on_ms = 9'(`BOOST_ON_MS0);
			2'h1: boost_on_ms = 9'(`BOOST_ON_MS1);
			2'h2: boost_on_ms = 9'(`BOOST_ON_MS2);
			2'h3: boost_on_ms = 9'(`BOOST_ON_MS3);
		endcase
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			boost_reg <= B_IDLE;
			boost_cnt_reg <= 9'h000;
		end else if (PHASE_PRESENT || OP_STATE == OP_COMACT || !run_mode) begin
			boost_reg <= B_IDLE;
			boost_cnt_reg <= 9'h000;
		end else begin
			unique case (boost_reg)
				B_IDLE: begin
					boost_reg <= B_ON;
					boost_cnt_reg <= 9'h000;
				end
				B_ON: if (ms_tick) begin
					if (boost_cnt_reg >= boost_on_ms - 9'h001) begin
						boost_reg <= B_OFF;
						boost_cnt_reg <= 9'h000;
					end else
						boost_cnt_reg <= boost_cnt_reg + 9'h001;
				end
				B_OFF: if (ms_tick) begin
					if (boost_cnt_reg == 9'(`BOOST_OFF_MS - 1)) begin
						boost_reg <= B_ON;
						boost_cnt_reg <= 9'h000;
					end else
						boost_cnt_reg <= boost_cnt_reg + 9'h001;
				end
			endcase
		end
	end

	// duty source priority: high-voltage off first
	always_comb begin
		if (high_voltage_force_off)
			duty_next = 9'h000;
		else if (low_voltage_force_on)
			duty_next = `DUTY_FULL;
		else if (pre_mode)
			duty_next = {1'b0, NVM_CFG.preexc_duty_field, 5'h00};
		else if (boost_reg == B_ON)
			duty_next = `DUTY_FULL;
		else if (boost_reg == B_OFF)
			duty_next = 9'h000;
		else
			duty_next = rise_limiter;
	end

	// only take a new duty at the boundary to avoid runt pulses
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			duty_reg <= 9'h000;
		else if (period_start)
			duty_reg <= duty_next;
	end

	// temperature slew filter, about one code per 31 periods
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			temp_filt_reg <= 8'h00;
			temp_cnt_reg <= 5'h00;
		end else if (period_start && run_mode) begin
			if (temp_cnt_reg >= `TEMP_STEP_PERIODS - 5'h01) begin
				temp_cnt_reg <= 5'h00;
				if (TEMP_SAMPLE > temp_filt_reg)
					temp_filt_reg <= temp_filt_reg + 8'h01;
				else if (TEMP_SAMPLE < temp_filt_reg)
					temp_filt_reg <= temp_filt_reg - 8'h01;
			end else
				temp_cnt_reg <= temp_cnt_reg + 5'h01;
		end
	end

	// threshold 125..160 in 5 degree steps, slope 50..400 mV/K
	assign high_temp_threshold = `TEMP_THR_BASE +
		8'(NVM_CFG.high_temp_threshold * `TEMP_THR_STEP);
	assign setpoint_drop = 12'(temp_filt_reg - high_temp_threshold) *
		12'(4'(NVM_CFG.high_temp_slope) + 4'h1);

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			HIGH_TEMP_FLAG <= 1'b0;
			SETPOINT_OUT <= 8'h00;
		end else begin
			HIGH_TEMP_FLAG <= temp_filt_reg > high_temp_threshold;
			if (temp_filt_reg <= high_temp_threshold)
				SETPOINT_OUT <= VOLTAGE_SETPOINT;
			else if (setpoint_drop >= 12'(VOLTAGE_SETPOINT))
				SETPOINT_OUT <= 8'h00;
			else
				SETPOINT_OUT <= VOLTAGE_SETPOINT - 8'(setpoint_drop);
		end
	end
endmodule // field_excitation_pwm_regulation

`default_nettype wire

/* File: bench/field_winding_model.sv */
// behavioural field winding with free-wheel current sense
`timescale 1ns/100ps
`default_nettype none
module field_winding_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic sw,
	input wire logic oc_cmd,
	output logic [7:0] cur,
	output logic oc
);
	// ramps while driven, decays while freewheeling
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cur <= 8'h00;
		else if (sw && cur != 8'hFF)
			cur <= cur + 8'h01;
		else if (!sw && cur != 8'h00)
			cur <= cur - 8'h01;
	end
	// trip only while the switch conducts, as a real shunt would
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			oc <= 1'b0;
		else
			oc <= oc_cmd && sw;
	end
endmodule // field_winding_model
`default_nettype wire

/* File: bench/field_pwm_asserts.sv */
// concurrent checks on the field pwm top ports
`timescale 1ns/100ps
`default_nettype none
module field_pwm_asserts (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [3:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic [7:0] VOLTAGE_SETPOINT,
	input wire logic OVER_CURRENT,
	input wire logic VBA_ABOVE_MAX,
	input wire logic FIELD_SWITCH,
	input wire logic HIGH_TEMP_FLAG,
	input wire logic [7:0] SETPOINT_OUT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// setpoint output lags reset release, so wait it out
	logic [1:0] age_reg;
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			age_reg <= 2'h0;
		else if (age_reg != 2'h3)
			age_reg <= age_reg + 2'h1;
	end
	sequence s_lim_wr;
		WR && ADDR == 4'h4;
	endsequence
	sequence s_lim_rd;
		RD && ADDR == 4'h4;
	endsequence
	sequence s_hv_span;
		VBA_ABOVE_MAX [*3];
	endsequence
	chk_hv_cut: assert property (VBA_ABOVE_MAX |=> !FIELD_SWITCH)
		else $error("switch on under high voltage");
	chk_hv_hold: assert property (s_hv_span |->
		!FIELD_SWITCH && !$past(FIELD_SWITCH))
		else $error("switch on during high voltage span");
	chk_oc_cut: assert property (OVER_CURRENT |=> !FIELD_SWITCH)
		else $error("switch on after over-current");
	chk_sp_lower: assert property (age_reg == 2'h3 &&
		$stable(VOLTAGE_SETPOINT) |-> SETPOINT_OUT <= VOLTAGE_SETPOINT)
		else $error("setpoint raised");
	chk_sp_cool: assert property (age_reg == 2'h3 && !HIGH_TEMP_FLAG &&
		$stable(VOLTAGE_SETPOINT) |-> SETPOINT_OUT == VOLTAGE_SETPOINT)
		else $error("setpoint changed while cool");
	chk_rd_hole: assert property (RD && ADDR[1:0] != 2'h0 |=>
		RDATA == 32'h0)
		else $error("unmapped read not zero");
	chk_rd_hold: assert property (!RD |=> $stable(RDATA))
		else $error("read data moved without read");
	chk_lim_back: assert property (s_lim_wr ##1 s_lim_rd |=>
		RDATA[7:0] == 8'($past(WDATA, 2)))
		else $error("limit readback wrong");
	chk_ctrl_rsvd: assert property (RD && ADDR == 4'h0 |=>
		RDATA[31:8] == 24'h0 && RDATA[3:2] == 2'h0)
		else $error("control reserved bits set");
endmodule // field_pwm_asserts
bind field_excitation_pwm_regulation field_pwm_asserts chk (.CLK, .SYS_RST,
	.ADDR, .WDATA, .WR, .RD, .RDATA, .VOLTAGE_SETPOINT, .OVER_CURRENT,
	.VBA_ABOVE_MAX, .FIELD_SWITCH, .HIGH_TEMP_FLAG, .SETPOINT_OUT);
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the field excitation pwm block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import field_pwm_pkg::*;
	localparam int SD = 4;
	localparam int SP = 8;
	localparam int MS = 16;
	localparam int PN = 256 * SD;
	logic CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic [3:0] ADDR = 4'h0;
	logic [31:0] WDATA = 32'h0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [31:0] RDATA;
	op_state_e OP_STATE = OP_NORMAL;
	nvm_cfg_s NVM_CFG = 12'h6C0;
	duty_t REG_DUTY = 9'h000;
	logic [7:0] VOLTAGE_SETPOINT = 8'h8F;
	logic [7:0] FIELD_CURRENT_SAMPLE;
	logic [7:0] TEMP_SAMPLE = 8'h64;
	logic OVER_CURRENT;
	logic VBA_BELOW_MIN = 1'b0;
	logic VBA_ABOVE_MAX = 1'b0;
	logic FORCE_ON_ENABLE = 1'b0;
	logic PHASE_PRESENT = 1'b1;
	logic FIELD_SWITCH;
	logic HIGH_TEMP_FLAG;
	logic [7:0] SETPOINT_OUT;
	logic oc_cmd = 1'b0;
	int err_total = 0;
	int samples_checked = 0;
	int hi;
	int ri;
	logic [31:0] rv;
	always #4 CLK = ~CLK;
	field_excitation_pwm_regulation #(.STEP_DIV_NORM(SD),
		.STEP_DIV_PRE(SP), .MS_DIV(MS)) dut (.CLK, .SYS_RST, .ADDR,
		.WDATA, .WR, .RD, .RDATA, .OP_STATE, .NVM_CFG, .REG_DUTY,
		.VOLTAGE_SETPOINT, .FIELD_CURRENT_SAMPLE, .TEMP_SAMPLE,
		.OVER_CURRENT, .VBA_BELOW_MIN, .VBA_ABOVE_MAX, .FORCE_ON_ENABLE,
		.PHASE_PRESENT, .FIELD_SWITCH, .HIGH_TEMP_FLAG, .SETPOINT_OUT);
	field_winding_model fw (.clk(CLK), .rst(SYS_RST), .sw(FIELD_SWITCH),
		.oc_cmd(oc_cmd), .cur(FIELD_CURRENT_SAMPLE), .oc(OVER_CURRENT));
	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		d = RDATA;
		@(posedge CLK);
	endtask
	// high cycles and rising edges of the switch over n cycles
	task automatic cnt(input int n);
		logic p;
		hi = 0;
		ri = 0;
		@(negedge CLK);
		p = FIELD_SWITCH;
		repeat (n) begin
			@(negedge CLK);
			if (FIELD_SWITCH === 1'b1)
				hi++;
			if (FIELD_SWITCH === 1'b1 && p !== 1'b1)
				ri++;
			p = FIELD_SWITCH;
		end
		@(posedge CLK);
	endtask
	task automatic wait_on;
		int k;
		for (k = 0; k < 4 * PN && FIELD_SWITCH !== 1'b1; k++)
			@(negedge CLK);
		if (k == 4 * PN) begin
			err_total++;
			$display("[FAIL] %0t switch never on", $time);
			summarize();
		end
		@(posedge CLK);
	endtask
	task automatic t_regs;
		rd(4'h0, rv);
		check(rv, 32'h10);
		rd(4'h4, rv);
		check(rv, 32'hFF);
		wr(4'h4, 32'h5A);
		rd(4'h4, rv);
		check(rv, 32'h5A);
		rd(4'h6, rv);
		check(rv, 32'h0);
		wr(4'h4, 32'hFF);
		check(32'(SETPOINT_OUT), 32'h8F);
		check(32'(HIGH_TEMP_FLAG), 32'h0);
		$display("regs done");
	endtask
	task automatic t_duty;
		REG_DUTY <= 9'h040;
		tick(2 * PN);
		cnt(4 * PN);
		check(32'(hi), 32'(4 * 64 * SD));
		check(32'(ri), 32'h4);
		OP_STATE <= OP_PRE;
		tick(2 * 256 * SP);
		cnt(2 * 256 * SP);
		check(32'(hi), 32'(2 * 96 * SP));
		check(32'(ri), 32'h2);
		OP_STATE <= OP_NORMAL;
		$display("duty done");
	endtask
	task automatic t_oc;
		REG_DUTY <= 9'h080;
		tick(2 * PN);
		wait_on();
		tick(20);
		oc_cmd <= 1'b1;
		@(posedge CLK);
		oc_cmd <= 1'b0;
		cnt(850);
		check(32'(hi <= 3), 32'h1);
		cnt(PN);
		check(32'(hi), 32'(128 * SD));
		$display("overcurrent done");
	endtask
	task automatic t_hv;
		wait_on();
		VBA_ABOVE_MAX <= 1'b1;
		tick(4);
		@(negedge CLK);
		check(32'(FIELD_SWITCH), 32'h0);
		@(posedge CLK);
		VBA_ABOVE_MAX <= 1'b0;
		$display("high voltage done");
	endtask
	task automatic t_full;
		REG_DUTY <= 9'h100;
		tick(2 * PN);
		cnt(33 * PN);
		check(32'((33 * PN - hi) inside {[1:8]}), 32'h1);
		wr(4'h0, 32'h11);
		tick(2 * PN);
		rd(4'h8, rv);
		check(32'(rv[16:8] <= 9'h0F5), 32'h1);
		wr(4'h0, 32'h10);
		$display("full duty done");
	endtask
	task automatic t_force;
		REG_DUTY <= 9'h000;
		FORCE_ON_ENABLE <= 1'b1;
		tick(300 * MS);
		VBA_BELOW_MIN <= 1'b1;
		cnt(PN);
		check(32'(hi), 32'h0);
		VBA_BELOW_MIN <= 1'b0;
		tick(410 * MS);
		VBA_BELOW_MIN <= 1'b1;
		tick(2 * PN);
		cnt(PN);
		check(32'(hi >= PN - 8), 32'h1);
		rd(4'h8, rv);
		check(32'(rv[20]), 32'h1);
		VBA_BELOW_MIN <= 1'b0;
		FORCE_ON_ENABLE <= 1'b0;
		$display("force-on done");
	endtask
	// on-time code 3 is 155 ms, over two periods, so one whole period is full on
	task automatic t_boost;
		PHASE_PRESENT <= 1'b0;
		tick(8);
		rd(4'h8, rv);
		check(32'(rv[21]), 32'h1);
		tick(1089);
		cnt(PN);
		check(32'(hi >= PN - 8), 32'h1);
		tick(1474);
		cnt(2 * PN);
		check(32'(hi), 32'h0);
		PHASE_PRESENT <= 1'b1;
		tick(4);
		rd(4'h8, rv);
		check(32'(rv[21]), 32'h0);
		PHASE_PRESENT <= 1'b0;
		OP_STATE <= OP_COMACT;
		tick(4);
		rd(4'h8, rv);
		check(32'(rv[21]), 32'h0);
		OP_STATE <= OP_PRE;
		tick(4);
		rd(4'h8, rv);
		check(32'(rv[21]), 32'h0);
		OP_STATE <= OP_NORMAL;
		PHASE_PRESENT <= 1'b1;
		$display("boost done");
	endtask
	task automatic t_rise;
		wr(4'h0, 32'h12);
		tick(2 * PN);
		REG_DUTY <= 9'h0C8;
		tick(2 * PN);
		rd(4'h8, rv);
		check(32'(rv[18]), 32'h1);
		check(32'(rv[16:8] < 9'h0C8), 32'h1);
		wr(4'h0, 32'h10);
		$display("rise limiter done");
	endtask
	initial begin
		tick(6);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		t_regs();
		t_duty();
		t_oc();
		t_hv();
		t_full();
		t_force();
		t_boost();
		t_rise();
		summarize();
	end
endmodule // tb_top
`default_nettype wire
